// file: odc_pkg.sv
package odc_pkg;

  // register offsets within page 0
  localparam logic [6:0] ODC_OFS_DRV_CTRL = 7'h26;
  localparam logic [6:0] ODC_OFS_RSVD     = 7'h27;
  localparam logic [6:0] ODC_OFS_STAGE    = 7'h28;
  localparam logic [6:0] ODC_OFS_SWITCH   = 7'h29;
  localparam logic [6:0] ODC_OFS_POP      = 7'h2A;

  // reset values
  localparam logic [7:0] ODC_RST_DRV_CTRL = 8'h00;
  localparam logic [7:0] ODC_RST_RSVD     = 8'h00;
  localparam logic [7:0] ODC_RST_STAGE    = 8'h00;
  localparam logic [7:0] ODC_RST_SWITCH   = 8'h00;
  localparam logic [7:0] ODC_RST_POP      = 8'h00;

  // field positions (lsb)
  localparam int ODC_RCOM_LSB  = 3;
  localparam int ODC_SCP_EN    = 2;
  localparam int ODC_SCP_MODE  = 1;
  localparam int ODC_CM_LSB    = 6;
  localparam int ODC_SSTEP_LSB = 0;
  localparam int ODC_LROUT_LSB = 6;
  localparam int ODC_RROUT_LSB = 4;
  localparam int ODC_LINK_LSB  = 0;
  localparam int ODC_PON_LSB   = 4;
  localparam int ODC_RAMP_LSB  = 2;
  localparam int ODC_WCM_SRC   = 1;
  // writable mask of the driver control register
  localparam logic [7:0] ODC_DRV_WMASK = 8'h3E;

  // timing
  localparam int unsigned ODC_CLK_HZ     = 25_000_000;
  localparam int unsigned ODC_CYC_PER_US = ODC_CLK_HZ / 1_000_000;

  // power-on delay by code, in microseconds
  localparam int unsigned ODC_PON_US [16] = '{
    0, 10, 100, 1_000, 10_000, 50_000, 50_000, 200_000,
    400_000, 800_000, 2_000_000, 4_000_000, 0, 0, 0, 0};
  // ramp step time by code, in microseconds
  localparam int unsigned ODC_RAMP_US [4] = '{0, 1_000, 2_000, 4_000};

  typedef enum logic [1:0] {
    ODC_SS_PER_FS,
    ODC_SS_PER_2FS,
    ODC_SS_OFF,
    ODC_SS_RSVD
  } odc_sstep_t;

  typedef enum logic [1:0] {
    ODC_LINK_INDEP,
    ODC_LINK_L_FOLLOWS_R,
    ODC_LINK_R_FOLLOWS_L,
    ODC_LINK_INDEP2
  } odc_link_t;

endpackage

// file: odc_interval_timer.sv
`timescale 1ns/100ps
// counts a duration in microsecond ticks, pulses done once at expiry
module odc_interval_timer #(
  parameter int unsigned CYC_PER_US = odc_pkg::ODC_CYC_PER_US
) (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        start,
  input  wire logic [22:0] dur_us,
  output logic             done
);
  initial begin
    if (CYC_PER_US < 1 || CYC_PER_US > 65535)
      $error("odc_interval_timer: CYC_PER_US out of range");
  end

  logic [15:0] pre_q;
  logic [22:0] left_q;
  logic        run_q;
  logic        done_q;
  wire         us_tick  = (pre_q == 16'(CYC_PER_US - 1));
  wire         expire   = run_q && (left_q == 23'h000000);

  always_ff @(posedge clk) begin
    if (rst) begin
      pre_q  <= 16'h0000;
      left_q <= 23'h000000;
      run_q  <= 1'b0;
      done_q <= 1'b0;
    end else begin
      done_q <= expire && !start;
      if (start) begin
        pre_q  <= 16'h0000;
        left_q <= dur_us;
        run_q  <= 1'b1;
      end else if (expire) begin
        run_q  <= 1'b0;
      end else if (run_q) begin
        pre_q  <= us_tick ? 16'h0000 : pre_q + 16'h0001;
        if (us_tick)
          left_q <= left_q - 23'h000001;
      end
    end
  end

  assign done = done_q;
endmodule

// file: odc_regs.sv
`timescale 1ns/100ps
// What this block does
// RULE_01 - right common driver config codes 000..100 select five modes
// RULE_02 - one bit enables short protection on all high-power drivers
// RULE_03 - protection mode: 0 limits current, 1 powers driver down
// RULE_04 - two-bit code selects output common-mode 1.35/1.5/1.65/1.8 V
// RULE_05 - soft-step: 00 per sample, 01 per two samples, 10 off
// RULE_06 - left converter routing: general, line or high-power path
// RULE_07 - right converter routing: general, line or high-power path
// RULE_08 - volume link: 01 left follows right, 10 right follows left
// RULE_09 - power-on delay codes 0000..1011 map to 0 us .. 4 s
// RULE_10 - ramp step interval codes give 0, 1, 2 or 4 ms
// RULE_11 - weak common-mode from supply divider (0) or band-gap (1)
// RULE_12 - driver control bits 7,6 and 0 read zero; host writes zeros
// RULE_13 - register after driver control is read-only zero
// RULE_14 - host never programs reserved codes of any field
// RULE_15 - delay, ramp and weak source live in the pop register 0x2A
// RULE_16 - soft-stepping moves applied volume one step per interval
// RULE_17 - on power-up wait the delay, then ramp one step per interval
// RULE_18 - all described fields are zero after reset
module odc_regs #(
  parameter int unsigned CYC_PER_US = odc_pkg::ODC_CYC_PER_US,
  parameter int unsigned RAMP_STEPS = 8
) (
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic [6:0] reg_addr,
  input  wire logic       reg_we,
  input  wire logic       reg_re,
  input  wire logic [7:0] reg_wdata,
  output logic      [7:0] reg_rdata,
  input  wire logic       fs_tick,
  input  wire logic [6:0] vol_target_l,
  input  wire logic [6:0] vol_target_r,
  input  wire logic       drv_power_req,
  input  wire logic       short_detect,
  output logic      [4:0] right_common_hp_driver_mode,
  output logic            short_current_limit,
  output logic            short_auto_power_down,
  output logic            hp_driver_shut,
  output logic      [1:0] common_mode_level,
  output logic      [2:0] left_path_sel,
  output logic      [2:0] right_path_sel,
  output logic      [6:0] vol_applied_l,
  output logic      [6:0] vol_applied_r,
  output logic            weak_cm_bandgap,
  output logic      [3:0] ramp_level,
  output logic            drv_powered
);
  initial begin
    if (RAMP_STEPS < 2 || RAMP_STEPS > 16)
      $error("odc_regs: RAMP_STEPS must be 2..16");
  end

  typedef enum logic [1:0] {ODC_P_OFF, ODC_P_DELAY, ODC_P_RAMP, ODC_P_ON}
    odc_pwr_t;

  // register storage
  logic [7:0] drv_q, stage_q, sw_q, pop_q, rdata_q;

  wire wr_drv   = reg_we && (reg_addr == odc_pkg::ODC_OFS_DRV_CTRL);
  wire wr_stage = reg_we && (reg_addr == odc_pkg::ODC_OFS_STAGE);
  wire wr_sw    = reg_we && (reg_addr == odc_pkg::ODC_OFS_SWITCH);
  wire wr_pop   = reg_we && (reg_addr == odc_pkg::ODC_OFS_POP);

  always_ff @(posedge clk) begin
    if (rst) begin
      drv_q   <= odc_pkg::ODC_RST_DRV_CTRL; // RULE_18
      stage_q <= odc_pkg::ODC_RST_STAGE;
      sw_q    <= odc_pkg::ODC_RST_SWITCH;
      pop_q   <= odc_pkg::ODC_RST_POP;
    end else begin
      // reserved driver bits are never stored
      if (wr_drv)
        drv_q <= reg_wdata & odc_pkg::ODC_DRV_WMASK; // RULE_12
      if (wr_stage)
        stage_q <= reg_wdata;
      if (wr_sw)
        sw_q <= reg_wdata;
      if (wr_pop)
        pop_q <= reg_wdata; // RULE_15
    end
  end

  // read mux; the reserved register and unmapped offsets read zero
  logic [7:0] rd_mux;
  always_comb begin
    unique case (reg_addr)
      odc_pkg::ODC_OFS_DRV_CTRL: rd_mux = drv_q;
      odc_pkg::ODC_OFS_RSVD:     rd_mux = odc_pkg::ODC_RST_RSVD; // RULE_13
      odc_pkg::ODC_OFS_STAGE:    rd_mux = stage_q;
      odc_pkg::ODC_OFS_SWITCH:   rd_mux = sw_q;
      odc_pkg::ODC_OFS_POP:      rd_mux = pop_q;
      default:                   rd_mux = 8'h00;
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst)
      rdata_q <= 8'h00;
    else if (reg_re)
      rdata_q <= rd_mux;
  end
  assign reg_rdata = rdata_q;

  // field views
  wire [2:0] rcom_f  = drv_q[odc_pkg::ODC_RCOM_LSB +: 3];
  wire       scp_en  = drv_q[odc_pkg::ODC_SCP_EN];
  wire       scp_md  = drv_q[odc_pkg::ODC_SCP_MODE];
  wire [1:0] cm_f    = stage_q[odc_pkg::ODC_CM_LSB +: 2];
  wire [1:0] ss_f    = stage_q[odc_pkg::ODC_SSTEP_LSB +: 2];
  wire [1:0] lrt_f   = sw_q[odc_pkg::ODC_LROUT_LSB +: 2];
  wire [1:0] rrt_f   = sw_q[odc_pkg::ODC_RROUT_LSB +: 2];
  wire [1:0] link_f  = sw_q[odc_pkg::ODC_LINK_LSB +: 2];
  wire [3:0] pon_f   = pop_q[odc_pkg::ODC_PON_LSB +: 4];
  wire [1:0] ramp_f  = pop_q[odc_pkg::ODC_RAMP_LSB +: 2];

  // one-hot decode of a routing code; reserved code selects nothing
  function automatic logic [2:0] route_dec(input logic [1:0] c);
    route_dec = (c == 2'h3) ? 3'h0 : 3'(3'h1 << c);
  endfunction

  // 0 diff of right main, 1 const cm, 2 single-ended,
  // 3 diff of left common, 4 ext feedback with left common at cm
  wire [4:0] rcom_dec = (rcom_f > 3'h4) ? 5'h00
                                         : 5'(5'h01 << rcom_f); // RULE_01

  // registered outputs: mode decode, protection, common-mode level, paths, weak source
  logic       sd_s1_q, sd_s2_q, sd_s3_q, sd_q;
  logic [4:0] rcom_q;
  logic       lim_q, apd_q, shut_q;
  logic [1:0] cm_q;
  logic [2:0] lpath_q, rpath_q;
  logic       wcm_q;

  always_ff @(posedge clk) begin
    if (rst) begin
      sd_s1_q <= 1'b0;
      sd_s2_q <= 1'b0;
      sd_s3_q <= 1'b0;
      sd_q    <= 1'b0;
      rcom_q  <= 5'h00;
      lim_q   <= 1'b0;
      apd_q   <= 1'b0;
      shut_q  <= 1'b0;
      cm_q    <= 2'h0;
      lpath_q <= 3'h0;
      rpath_q <= 3'h0;
      wcm_q   <= 1'b0;
    end else begin
      sd_s1_q <= short_detect;
      sd_s2_q <= sd_s1_q;
      sd_s3_q <= sd_s2_q;
      if (sd_s2_q == sd_s3_q)
        sd_q <= sd_s3_q;
      rcom_q  <= rcom_dec; // RULE_01
      lim_q   <= scp_en && !scp_md; // RULE_02
      apd_q   <= scp_en && scp_md; // RULE_03
      // shutdown holds until power request drops or protection is relaxed
      if (!drv_power_req || !(scp_en && scp_md))
        shut_q <= 1'b0;
      else if (sd_q)
        shut_q <= 1'b1; // RULE_03
      cm_q    <= cm_f; // RULE_04
      lpath_q <= route_dec(lrt_f); // RULE_06
      rpath_q <= route_dec(rrt_f); // RULE_07
      wcm_q   <= pop_q[odc_pkg::ODC_WCM_SRC]; // RULE_11
    end
  end

  // volume linking and soft-stepping
  wire [6:0] tgt_l = (link_f == 2'(odc_pkg::ODC_LINK_L_FOLLOWS_R))
                     ? vol_target_r : vol_target_l; // RULE_08
  wire [6:0] tgt_r = (link_f == 2'(odc_pkg::ODC_LINK_R_FOLLOWS_L))
                     ? vol_target_l : vol_target_r; // RULE_08

  function automatic logic [6:0] step_to(input logic [6:0] cur,
                                         input logic [6:0] tgt);
    if (cur < tgt)
      step_to = cur + 7'h01;
    else if (cur > tgt)
      step_to = cur - 7'h01;
    else
      step_to = cur;
  endfunction

  logic       fs_odd_q;
  logic [6:0] vol_l_q, vol_r_q;
  // reserved soft-step code paces like one step per sample
  wire ss_off  = (ss_f == 2'(odc_pkg::ODC_SS_OFF));
  wire ss_two  = (ss_f == 2'(odc_pkg::ODC_SS_PER_2FS));
  wire ss_step = fs_tick && (!ss_two || fs_odd_q); // RULE_05

  always_ff @(posedge clk) begin
    if (rst) begin
      fs_odd_q <= 1'b0;
      vol_l_q  <= 7'h00;
      vol_r_q  <= 7'h00;
    end else begin
      if (fs_tick)
        fs_odd_q <= !fs_odd_q;
      if (ss_off) begin
        vol_l_q <= tgt_l; // RULE_05
        vol_r_q <= tgt_r;
      end else if (ss_step) begin
        vol_l_q <= step_to(vol_l_q, tgt_l); // RULE_16
        vol_r_q <= step_to(vol_r_q, tgt_r); // RULE_16
      end
    end
  end

  // power-on delay then stepped ramp
  odc_pwr_t   pst_q, pst_d;
  logic [3:0] lvl_q;
  logic       tmr_start;
  logic [22:0] tmr_dur;
  wire        tmr_done;
  wire        ramp_top = (lvl_q == 4'(RAMP_STEPS - 1));

  always_comb begin
    pst_d     = pst_q;
    tmr_start = 1'b0;
    tmr_dur   = 23'(odc_pkg::ODC_RAMP_US[ramp_f]); // RULE_10
    unique case (pst_q)
      ODC_P_OFF: if (drv_power_req) begin
        pst_d     = ODC_P_DELAY;
        tmr_start = 1'b1;
        tmr_dur   = 23'(odc_pkg::ODC_PON_US[pon_f]); // RULE_09
      end
      ODC_P_DELAY: if (!drv_power_req) begin
        pst_d = ODC_P_OFF;
      end else if (tmr_done) begin
        pst_d     = ODC_P_RAMP; // RULE_17
        tmr_start = 1'b1;
      end
      ODC_P_RAMP: if (!drv_power_req || shut_q) begin
        pst_d = ODC_P_OFF;
      end else if (tmr_done) begin
        pst_d     = ramp_top ? ODC_P_ON : ODC_P_RAMP;
        tmr_start = !ramp_top;
      end
      ODC_P_ON: if (!drv_power_req || shut_q) begin
        pst_d = ODC_P_OFF;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      pst_q <= ODC_P_OFF;
      lvl_q <= 4'h0;
    end else begin
      pst_q <= pst_d;
      if (pst_d == ODC_P_OFF)
        lvl_q <= 4'h0;
      else if (pst_q == ODC_P_RAMP && tmr_done && !ramp_top)
        lvl_q <= lvl_q + 4'h1; // RULE_17
    end
  end

  odc_interval_timer #(
    .CYC_PER_US (CYC_PER_US)
  ) u_timer (
    .clk    (clk),
    .rst    (rst),
    .start  (tmr_start),
    .dur_us (tmr_dur),
    .done   (tmr_done)
  );

  logic pwr_q;
  always_ff @(posedge clk) begin
    if (rst)
      pwr_q <= 1'b0;
    else
      pwr_q <= (pst_d == ODC_P_ON);
  end

  assign right_common_hp_driver_mode = rcom_q;
  assign short_current_limit         = lim_q;
  assign short_auto_power_down       = apd_q;
  assign hp_driver_shut              = shut_q;
  assign common_mode_level           = cm_q;
  assign left_path_sel               = lpath_q;
  assign right_path_sel              = rpath_q;
  assign vol_applied_l               = vol_l_q;
  assign vol_applied_r               = vol_r_q;
  assign weak_cm_bandgap             = wcm_q;
  assign ramp_level                  = lvl_q;
  assign drv_powered                 = pwr_q;

  // checks
  chk_rcom_decode: assert property (@(posedge clk) disable iff (rst) // RULE_01
    $stable(drv_q) && rcom_f == 3'h4 |=> rcom_q == 5'h10)
    else $error("right common mode decode wrong");
  chk_scp_enable: assert property (@(posedge clk) disable iff (rst) // RULE_02
    !scp_en && $stable(drv_q) |=> !lim_q && !apd_q)
    else $error("protection active while disabled");
  chk_scp_mode: assert property (@(posedge clk) disable iff (rst) // RULE_03
    scp_en && !scp_md && $stable(drv_q) |=> lim_q && !shut_q)
    else $error("current limit mode wrong");
  chk_cm_level: assert property (@(posedge clk) disable iff (rst) // RULE_04
    $stable(stage_q) |=> cm_q == $past(cm_f))
    else $error("common-mode level not applied");
  chk_route_left: assert property (@(posedge clk) disable iff (rst) // RULE_06
    lrt_f == 2'h2 && $stable(sw_q) |=> lpath_q == 3'h4)
    else $error("left high-power path not selected");
  chk_route_right: assert property (@(posedge clk) disable iff (rst) // RULE_07
    rrt_f == 2'h1 && $stable(sw_q) |=> rpath_q == 3'h2)
    else $error("right line path not selected");
  chk_rsvd_read: assert property (@(posedge clk) disable iff (rst) // RULE_13
    reg_re && reg_addr == odc_pkg::ODC_OFS_RSVD |=> reg_rdata == 8'h00)
    else $error("reserved register read nonzero");
  chk_drv_rsvd_bits: assert property (@(posedge clk) // RULE_12
    disable iff (rst) reg_re && reg_addr == odc_pkg::ODC_OFS_DRV_CTRL
    |=> reg_rdata[7:6] == 2'h0 && reg_rdata[0] == 1'b0)
    else $error("reserved driver bits read nonzero");
  chk_soft_step: assert property (@(posedge clk) disable iff (rst) // RULE_16
    !ss_off && !$past(ss_off) |-> (vol_l_q - $past(vol_l_q) == 7'h01)
      || (vol_l_q == $past(vol_l_q))
      || ($past(vol_l_q) - vol_l_q == 7'h01))
    else $error("applied volume jumped during soft-step");
  chk_link_left: assert property (@(posedge clk) disable iff (rst) // RULE_08
    link_f == 2'h1 && ss_off && $stable(link_f) && $stable(vol_target_r)
    |=> vol_l_q == $past(vol_target_r))
    else $error("left volume not following right");
  chk_ramp_order: assert property (@(posedge clk) disable iff (rst) // RULE_17
    pst_q == ODC_P_OFF && drv_power_req |=> pst_q == ODC_P_DELAY
      && lvl_q == 4'h0)
    else $error("power-up skipped the delay");
endmodule

// file: odc_host_model.sv
`timescale 1ns/100ps
// host side of the register port; every change lands on a falling edge
module odc_host_model (
  output logic      [6:0] reg_addr,
  output logic            reg_we,
  output logic            reg_re,
  output logic      [7:0] reg_wdata,
  input  wire logic [7:0] reg_rdata,
  input  wire logic       clk
);
  initial begin
    reg_addr  = 7'h00;
    reg_we    = 1'h0;
    reg_re    = 1'h0;
    reg_wdata = 8'h00;
  end

  // one-cycle strobe; data is scrambled once the strobe has gone
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    @(negedge clk);
    reg_addr  = a;
    reg_wdata = d;
    reg_we    = 1'h1;
    @(negedge clk);
    reg_we    = 1'h0;
    reg_wdata = ~d;
  endtask

  // read data is registered, so it is taken one edge after the strobe
  task automatic rd(input logic [6:0] a, output logic [7:0] d);
    @(negedge clk);
    reg_addr = a;
    reg_re   = 1'h1;
    @(negedge clk);
    reg_re = 1'h0;
    d      = reg_rdata;
  endtask
endmodule

// file: tb_odc_regs.sv
`timescale 1ns/100ps
module tb_odc_regs;
  // short microsecond so the power sequence fits the run
  localparam int unsigned CYC   = 1;
  localparam int unsigned STEPS = 4;
  // request to powered: delay and each ramp interval cost two extra cycles,
  // and the last interval is spent at the top level
  localparam int PWR_CYC  = 1 + (100 * CYC + 2) + STEPS * (1000 * CYC + 2);
  localparam int FAST_CYC = 1 + 2 + STEPS * 2;
  typedef struct {
    logic [6:0] a;
    logic [7:0] wd;
    logic [7:0] rb;
    logic [4:0] mode;
    logic       lim;
    logic       apd;
    logic [1:0] cm;
    logic [2:0] ls;
    logic [2:0] rs;
    logic       wcm;
  } odc_row_t;

  logic       clk, rst, reg_we, reg_re, fs_tick, drv_power_req;
  logic       short_detect, short_current_limit, short_auto_power_down;
  logic       hp_driver_shut, weak_cm_bandgap, drv_powered;
  logic [6:0] reg_addr, vol_target_l, vol_target_r;
  logic [6:0] vol_applied_l, vol_applied_r;
  logic [7:0] reg_wdata, reg_rdata, d;
  logic [4:0] right_common_hp_driver_mode;
  logic [1:0] common_mode_level;
  logic [2:0] left_path_sel, right_path_sel;
  logic [3:0] ramp_level;
  int         fail_count, tests_run, n;
  logic [6:0] ofs [5] = '{7'h26, 7'h27, 7'h28, 7'h29, 7'h2A};
  odc_row_t   rows [15] = '{
    '{7'h26, 8'h06, 8'h06, 5'h01, 1'h0, 1'h1, 2'h0, 3'h1, 3'h1, 1'h0},
    '{7'h26, 8'h00, 8'h00, 5'h01, 1'h0, 1'h0, 2'h0, 3'h1, 3'h1, 1'h0},
    '{7'h26, 8'h08, 8'h08, 5'h02, 1'h0, 1'h0, 2'h0, 3'h1, 3'h1, 1'h0},
    '{7'h26, 8'h14, 8'h14, 5'h04, 1'h1, 1'h0, 2'h0, 3'h1, 3'h1, 1'h0},
    '{7'h26, 8'h1A, 8'h1A, 5'h08, 1'h0, 1'h0, 2'h0, 3'h1, 3'h1, 1'h0},
    '{7'h26, 8'h26, 8'h26, 5'h10, 1'h0, 1'h1, 2'h0, 3'h1, 3'h1, 1'h0},
    '{7'h27, 8'h55, 8'h00, 5'h10, 1'h0, 1'h1, 2'h0, 3'h1, 3'h1, 1'h0},
    '{7'h28, 8'h41, 8'h41, 5'h10, 1'h0, 1'h1, 2'h1, 3'h1, 3'h1, 1'h0},
    '{7'h28, 8'h80, 8'h80, 5'h10, 1'h0, 1'h1, 2'h2, 3'h1, 3'h1, 1'h0},
    '{7'h28, 8'hC2, 8'hC2, 5'h10, 1'h0, 1'h1, 2'h3, 3'h1, 3'h1, 1'h0},
    '{7'h29, 8'h90, 8'h90, 5'h10, 1'h0, 1'h1, 2'h3, 3'h4, 3'h2, 1'h0},
    '{7'h29, 8'h61, 8'h61, 5'h10, 1'h0, 1'h1, 2'h3, 3'h2, 3'h4, 1'h0},
    '{7'h2A, 8'h02, 8'h02, 5'h10, 1'h0, 1'h1, 2'h3, 3'h2, 3'h4, 1'h1},
    '{7'h2A, 8'hBC, 8'hBC, 5'h10, 1'h0, 1'h1, 2'h3, 3'h2, 3'h4, 1'h0},
    '{7'h30, 8'hAA, 8'h00, 5'h10, 1'h0, 1'h1, 2'h3, 3'h2, 3'h4, 1'h0}};

  odc_regs #(.CYC_PER_US(CYC), .RAMP_STEPS(STEPS)) DUT (
    .clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_we(reg_we),
    .reg_re(reg_re), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .fs_tick(fs_tick), .vol_target_l(vol_target_l),
    .vol_target_r(vol_target_r), .drv_power_req(drv_power_req),
    .short_detect(short_detect),
    .right_common_hp_driver_mode(right_common_hp_driver_mode),
    .short_current_limit(short_current_limit),
    .short_auto_power_down(short_auto_power_down),
    .hp_driver_shut(hp_driver_shut), .common_mode_level(common_mode_level),
    .left_path_sel(left_path_sel), .right_path_sel(right_path_sel),
    .vol_applied_l(vol_applied_l), .vol_applied_r(vol_applied_r),
    .weak_cm_bandgap(weak_cm_bandgap), .ramp_level(ramp_level),
    .drv_powered(drv_powered));

  odc_host_model host (
    .reg_addr(reg_addr), .reg_we(reg_we), .reg_re(reg_re),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .clk(clk));

  always #20 clk = ~clk;

  task automatic check(input logic [15:0] got, input logic [15:0] exp,
                       input string what);
    tests_run++;
    if (got !== exp) begin
      fail_count++;
      $display("mismatch at %0t: %s got %h expected %h", $time, what, got,
               exp);
    end
  endtask

  task automatic tick(input int k);
    repeat (k) begin
      @(negedge clk);
      fs_tick = 1'h1;
      @(negedge clk);
      fs_tick = 1'h0;
    end
    repeat (2) @(negedge clk);
  endtask

  task automatic vols(input logic [6:0] l, input logic [6:0] r);
    check(16'(vol_applied_l), 16'(l), "left volume");
    check(16'(vol_applied_r), 16'(r), "right volume");
  endtask

  task automatic give_verdict();
    $display("checks %0d, mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  initial begin
    clk = 1'h0;
    rst = 1'h1;
    fs_tick = 1'h0;
    vol_target_l = 7'h00;
    vol_target_r = 7'h00;
    drv_power_req = 1'h0;
    short_detect = 1'h0;
    fail_count = 0;
    tests_run = 0;
    repeat (3) @(negedge clk);
    rst = 1'h0;
    repeat (3) @(negedge clk);
    foreach (ofs[i]) begin
      host.rd(ofs[i], d);
      check(16'(d), 16'h00, "reset value");
    end
    check(16'(right_common_hp_driver_mode), 16'h01, "reset mode");
    check(16'({left_path_sel, right_path_sel}), 16'h09, "reset");
    check(16'({drv_powered, ramp_level}), 16'h00, "reset ramp");
    foreach (rows[i]) begin
      odc_row_t r;
      r = rows[i];
      // the reserved register is only read, never written
      if (r.a != 7'h27)
        host.wr(r.a, r.wd);
      host.rd(r.a, d);
      check(16'(d), 16'(r.rb), "readback");
      check(16'(right_common_hp_driver_mode), 16'(r.mode), "mode");
      check(16'(short_current_limit), 16'(r.lim), "limit");
      check(16'(short_auto_power_down), 16'(r.apd), "apd");
      check(16'(common_mode_level), 16'(r.cm), "cm");
      check(16'(left_path_sel), 16'(r.ls), "left path");
      check(16'(right_path_sel), 16'(r.rs), "right path");
      check(16'(weak_cm_bandgap), 16'(r.wcm), "weak cm");
    end
    // per-sample stepping, then every second sample, then off
    host.wr(7'h28, 8'h00);
    host.wr(7'h29, 8'h00);
    vol_target_l = 7'h05;
    vol_target_r = 7'h03;
    tick(1);
    vols(7'h01, 7'h01);
    tick(4);
    vols(7'h05, 7'h03);
    host.wr(7'h28, 8'h01);
    vol_target_l = 7'h00;
    tick(4);
    vols(7'h03, 7'h03);
    host.wr(7'h28, 8'h02);
    vol_target_l = 7'h09;
    repeat (3) @(negedge clk);
    vols(7'h09, 7'h03);
    // volume linking both ways and back to independent
    host.wr(7'h29, 8'h01);
    vol_target_r = 7'h14;
    repeat (3) @(negedge clk);
    vols(7'h14, 7'h14);
    host.wr(7'h29, 8'h02);
    vol_target_l = 7'h07;
    repeat (3) @(negedge clk);
    vols(7'h07, 7'h07);
    host.wr(7'h29, 8'h03);
    repeat (3) @(negedge clk);
    vols(7'h07, 7'h14);
    // 100 us delay, then three 1 ms steps and one interval held at the top
    host.wr(7'h2A, 8'h24);
    drv_power_req = 1'h1;
    repeat (90) @(negedge clk);
    check(16'({drv_powered, ramp_level}), 16'h00, "early ramp");
    for (n = 90; n < 5000 && drv_powered !== 1'h1; n++) @(negedge clk);
    check(16'(n), 16'(PWR_CYC), "power time");
    check(16'(ramp_level), 16'(STEPS - 1), "ramp top");
    // short in power-down mode, then current-limit mode
    host.wr(7'h26, 8'h06);
    short_detect = 1'h1;
    for (n = 0; n < 20 && hp_driver_shut !== 1'h1; n++) @(negedge clk);
    repeat (3) @(negedge clk);
    check(16'({hp_driver_shut, drv_powered}), 16'h2, "shutdown");
    host.wr(7'h26, 8'h04);
    repeat (3) @(negedge clk);
    check(16'(short_current_limit), 16'h1, "limit on");
    check(16'(hp_driver_shut), 16'h0, "shut cleared");
    short_detect = 1'h0;
    drv_power_req = 1'h0;
    host.wr(7'h26, 8'h00);
    repeat (3) @(negedge clk);
    check(16'({short_current_limit, drv_powered}), 16'h0, "off");
    // zero delay and zero step time still cost two cycles per interval
    host.wr(7'h2A, 8'h00);
    drv_power_req = 1'h1;
    for (n = 0; n < 40 && drv_powered !== 1'h1; n++) @(negedge clk);
    check(16'(n), 16'(FAST_CYC), "fast power");
    drv_power_req = 1'h0;
    repeat (3) @(negedge clk);
    check(16'({drv_powered, ramp_level}), 16'h00, "power drop");
    // reset in mid-run clears a stored value
    host.wr(7'h28, 8'hC1);
    rst = 1'h1;
    repeat (2) @(negedge clk);
    rst = 1'h0;
    host.rd(7'h28, d);
    check(16'(d), 16'h00, "second reset");
    give_verdict();
  end
endmodule
